// ---- common/asr_pkg.sv ----
// Purpose: constants for the task-file status and control block
// Assumes: 125 MHz core clock, byte-wide task-file port
// Notes: offsets are task-file register offsets
package asr_pkg;
    // clock
    localparam int unsigned CLK_PERIOD_NS = 8;
    // register offsets
    localparam logic [3:0] OFS_STATUS = 4'h7;
    localparam logic [3:0] OFS_DRIVE_HEAD = 4'h6;
    localparam logic [3:0] OFS_COMMAND = 4'h7;
    localparam logic [3:0] OFS_ALT_STATUS = 4'he;
    localparam logic [3:0] OFS_DEVICE_CONTROL = 4'he;
    localparam logic [3:0] OFS_DRIVE_ADDRESS = 4'hf;
    // status bit positions
    localparam int BIT_BUSY = 7;
    localparam int BIT_READY = 6;
    localparam int BIT_WRITE_FAULT = 5;
    localparam int BIT_SEEK_COMPLETE = 4;
    localparam int BIT_DATA_REQUEST = 3;
    localparam int BIT_FIXED_DATA = 2;
    localparam int BIT_INDEX = 1;
    localparam int BIT_ERROR = 0;
    // device control positions
    localparam int BIT_SOFT_RESET = 2;
    localparam int BIT_INT_MASK_N = 1;
    // drive/head positions
    localparam int BIT_DRIVE_SELECT = 4;
    // drive address positions
    localparam int BIT_WRITE_GATE_N = 6;
    // reset values
    localparam logic [7:0] RST_DRIVE_HEAD = 8'ha0;
    localparam logic RST_INT_MASK_N = 1'b0;
    // timing, figures as printed
    localparam int unsigned BUSY_SET_NS = 400;
    localparam int unsigned CLASS2_DRQ_US = 700;
    localparam int unsigned CLASS3_DRQ_MS = 20;
    localparam int unsigned BUSY_CLEAR_NS = 400;
    localparam int unsigned BUSY_SET_CYC = BUSY_SET_NS / CLK_PERIOD_NS;
    localparam int unsigned BUSY_CLEAR_CYC = BUSY_CLEAR_NS / CLK_PERIOD_NS;
    localparam int unsigned CLASS2_DRQ_CYC = (CLASS2_DRQ_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned CLASS3_DRQ_CYC = (CLASS3_DRQ_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TMR_W = 22;
    typedef enum logic [1:0] {CMD_CLASS1, CMD_CLASS2, CMD_CLASS3} asr_class_type;
endpackage : asr_pkg

// ---- common/asr_hs_if.sv ----
// Purpose: carries drive/head state to the drive address formatter
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
interface asr_hs_if;
    logic [7:0] drive_head;
    logic write_active;
    logic [7:0] drive_address;
    modport src (output drive_head, output write_active, input drive_address);
    modport fmt (input drive_head, input write_active, output drive_address);
endinterface : asr_hs_if

// ---- rtl/asr_drive_addr.sv ----
// Purpose: forms the legacy drive address byte
// Assumes: drive/head value is registered upstream
// Notes: purely combinational
`timescale 1ns/1ps
module asr_drive_addr
    import asr_pkg::*;
(
    asr_hs_if.fmt hs
);
    always_comb
    begin
        // bit 7 has no defined value; driven as one
        hs.drive_address[7] = 1'b1;
        hs.drive_address[BIT_WRITE_GATE_N] = ~hs.write_active;
        hs.drive_address[5:2] = ~hs.drive_head[3:0];
        hs.drive_address[1] = ~hs.drive_head[BIT_DRIVE_SELECT];
        hs.drive_address[0] = hs.drive_head[BIT_DRIVE_SELECT];
    end
endmodule : asr_drive_addr

// ---- rtl/asr_status_regs.sv ----
// Purpose: task-file status, device control and drive address logic
// Assumes: host strobes are already synchronised to i_clk
// Notes: media engine reports events through the core port group
//
// Overview of operation
// - busy set while device owns registers
// - dma request only with busy or drq
// - ready cleared until commands can be accepted
// - write fault flag reflects fault event
// - seek complete set whenever ready
// - drq set when data must move
// - fixed data flag on corrected error
// - index bit always reads zero
// - error flag when previous command failed
// - failing sector address left in registers
// - device control writable even while busy
// - control bits 7..3 and 0 ignored
// - soft reset bit holds device in reset
// - interrupt enable active low, resets zero
// - write gate low during write
// - drive address shows inverted head bits
// - drive select bits low when selected
// - drive address bit 7 undefined
// - class 1 sets busy within 400 ns
// - class 2 drq within 700 us
// - class 3 drq within 20 ms
// - status read clears interrupt, alternate not
// - drive/head holds drive select and head
`timescale 1ns/1ps
module asr_status_regs
    import asr_pkg::*;
#(
    parameter int unsigned CLASS2_LIMIT = CLASS2_DRQ_CYC,
    parameter int unsigned CLASS3_LIMIT = CLASS3_DRQ_CYC
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // host task-file port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // core events
    input wire logic i_core_ready,
    input wire logic [1:0] i_cmd_class,
    input wire logic i_buffer_ready,
    input wire logic i_xfer_done,
    input wire logic i_cmd_error,
    input wire logic i_write_fault,
    input wire logic i_corrected,
    input wire logic i_dma_cmd,
    input wire logic i_dma_want,
    input wire logic i_int_event,
    // outputs to host and core
    output logic o_irq,
    output logic o_dmarq,
    output logic o_soft_reset,
    output logic o_cmd_strobe,
    output logic [7:0] o_cmd_code,
    output logic o_write_active
);
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_XFER} asr_state_type;

    // ----------------------------------------------------------
    // decode
    // ----------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    asr_state_type state;
    logic busy;
    logic ready;
    logic data_request_flag;
    logic write_fault_flag;
    logic fixed_data_flag;
    logic error_flag;
    logic soft_reset_bit;
    logic interrupt_mask_n;
    logic int_pending;
    logic [7:0] drive_head;
    logic [TMR_W-1:0] timer;
    logic core_reset;
    logic cmd_wr;
    logic [7:0] status_byte;
    logic deadline;
    logic status_rd;
    asr_hs_if hs ();

    assign core_reset = i_sys_rst | soft_reset_bit;
    // the command register is locked out while busy
    assign cmd_wr = i_wr & hit(i_addr, OFS_COMMAND) & ~busy;
    // only the primary copy clears the pending interrupt
    assign status_rd = i_rd & hit(i_addr, OFS_STATUS);

    // ----------------------------------------------------------
    // device control
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            soft_reset_bit <= 1'b0;
            o_soft_reset <= 1'b0;
            interrupt_mask_n <= RST_INT_MASK_N;
        end
        else if (i_wr & hit(i_addr, OFS_DEVICE_CONTROL))
        begin
            // only the reset and mask bits are kept
            soft_reset_bit <= i_wdata[BIT_SOFT_RESET];
            // the core sees soft reset on the same edge as the bit itself
            o_soft_reset <= i_wdata[BIT_SOFT_RESET];
            interrupt_mask_n <= i_wdata[BIT_INT_MASK_N];
        end
        else if (soft_reset_bit)
        begin
            interrupt_mask_n <= RST_INT_MASK_N;
        end
    end

    // ----------------------------------------------------------
    // drive/head
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (core_reset)
        begin
            drive_head <= RST_DRIVE_HEAD;
        end
        else if (i_wr & hit(i_addr, OFS_DRIVE_HEAD) & ~busy)
        begin
            drive_head <= i_wdata;
        end
    end

    // ----------------------------------------------------------
    // deadline watch
    // ----------------------------------------------------------
    // the compare stops one short of the limit: the command edge
    // counts as the first cycle of the allowed span, so the data
    // request never lands a cycle past the deadline
    always_comb
    begin
        deadline = 1'b0;
        if (i_cmd_class == 2'(CMD_CLASS2))
        begin
            deadline = (timer >= TMR_W'(CLASS2_LIMIT - 1));
        end
        else if (i_cmd_class == 2'(CMD_CLASS3))
        begin
            deadline = (timer >= TMR_W'(CLASS3_LIMIT - 1));
        end
    end

    // ----------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (core_reset)
        begin
            state <= ST_IDLE;
            busy <= 1'b1;
            data_request_flag <= 1'b0;
            timer <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    data_request_flag <= 1'b0;
                    // busy until the core can take commands
                    busy <= ~i_core_ready;
                    timer <= '0;
                    if (cmd_wr)
                    begin
                        // busy on the next edge, well inside 400 ns
                        busy <= 1'b1;
                        state <= ST_BUSY;
                    end
                end
                ST_BUSY:
                begin
                    timer <= timer + 1'b1;
                    if (i_buffer_ready)
                    begin
                        data_request_flag <= 1'b1;
                        state <= ST_XFER;
                    end
                    else if (i_xfer_done)
                    begin
                        busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                    else if (deadline)
                    begin
                        // deadline missed: data request forced on time
                        data_request_flag <= 1'b1;
                        state <= ST_XFER;
                    end
                end
                ST_XFER:
                begin
                    // busy drops one edge after drq rises
                    busy <= 1'b0;
                    if (i_xfer_done)
                    begin
                        data_request_flag <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------
    // ready and result flags
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (core_reset)
        begin
            ready <= 1'b0;
            write_fault_flag <= 1'b0;
            fixed_data_flag <= 1'b0;
            error_flag <= 1'b0;
        end
        else
        begin
            ready <= i_core_ready;
            // set wins over clear by a new command
            write_fault_flag <= i_write_fault | (write_fault_flag & ~cmd_wr);
            fixed_data_flag <= i_corrected | (fixed_data_flag & ~cmd_wr);
            // cause and sector address stay in the core's task file
            error_flag <= i_cmd_error | (error_flag & ~cmd_wr);
        end
    end

    // ----------------------------------------------------------
    // interrupt and dma request
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (core_reset)
        begin
            int_pending <= 1'b0;
        end
        else if (i_int_event)
        begin
            int_pending <= 1'b1;
        end
        else if (status_rd)
        begin
            int_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (core_reset)
        begin
            o_irq <= 1'b0;
            o_dmarq <= 1'b0;
        end
        else
        begin
            o_irq <= int_pending & ~interrupt_mask_n & ~status_rd;
            o_dmarq <= i_dma_cmd & i_dma_want & (busy | data_request_flag);
        end
    end

    // ----------------------------------------------------------
    // read data
    // ----------------------------------------------------------
    always_comb
    begin
        status_byte = '0;
        status_byte[BIT_BUSY] = busy;
        status_byte[BIT_READY] = ready;
        status_byte[BIT_WRITE_FAULT] = write_fault_flag;
        status_byte[BIT_SEEK_COMPLETE] = ready;
        status_byte[BIT_DATA_REQUEST] = data_request_flag;
        status_byte[BIT_FIXED_DATA] = fixed_data_flag;
        status_byte[BIT_INDEX] = 1'b0;
        status_byte[BIT_ERROR] = error_flag;
    end

    assign hs.drive_head = drive_head;
    assign hs.write_active = o_write_active;

    asr_drive_addr u_drive_addr (
        .hs(hs.fmt)
    );

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_rdata <= '0;
        end
        else if (i_rd & (hit(i_addr, OFS_STATUS) | hit(i_addr, OFS_ALT_STATUS)))
        begin
            o_rdata <= status_byte;
        end
        else if (i_rd & hit(i_addr, OFS_DRIVE_ADDRESS))
        begin
            o_rdata <= hs.drive_address;
        end
        else if (i_rd & hit(i_addr, OFS_DRIVE_HEAD))
        begin
            o_rdata <= drive_head;
        end
        else if (i_rd)
        begin
            o_rdata <= '0;
        end
    end

    // ----------------------------------------------------------
    // core-side outputs
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (core_reset)
        begin
            o_cmd_strobe <= 1'b0;
            o_cmd_code <= '0;
            o_write_active <= 1'b0;
        end
        else
        begin
            o_cmd_strobe <= cmd_wr;
            if (cmd_wr)
            begin
                o_cmd_code <= i_wdata;
            end
            o_write_active <= (state != ST_IDLE) & (i_cmd_class != 2'(CMD_CLASS1)) & data_request_flag;
        end
    end
endmodule : asr_status_regs

// ---- dv/asr_status_regs_props.sv ----
// Purpose: port-level properties of the status and control block
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every instance of the block
`timescale 1ns/1ps
module asr_status_regs_props
    import asr_pkg::*;
#(
    parameter int unsigned CLASS2_LIMIT = 20,
    parameter int unsigned CLASS3_LIMIT = 20
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // host port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    // core side
    input wire logic i_xfer_done,
    input wire logic i_dma_cmd,
    input wire logic i_dma_want,
    input wire logic i_int_event,
    input wire logic o_irq,
    input wire logic o_dmarq,
    input wire logic o_soft_reset,
    input wire logic o_cmd_strobe,
    input wire logic [7:0] o_cmd_code
);
    // ----
    // properties
    // ----
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    chk_cmd_from_write: assert property (o_cmd_strobe |-> $past(i_wr) && $past(i_addr) == OFS_COMMAND)
        else $error("command strobe without command write");
    chk_cmd_code_copy: assert property (o_cmd_strobe |-> o_cmd_code == $past(i_wdata))
        else $error("command code differs from written byte");
    chk_busy_locks_out: assert property ((o_cmd_strobe && !i_xfer_done) ##1 (i_wr && i_addr == OFS_COMMAND)
        |=> !o_cmd_strobe)
        else $error("command taken while busy");
    chk_dmarq_cause: assert property (o_dmarq |-> $past(i_dma_cmd && i_dma_want))
        else $error("dma request without dma command");
    chk_softrst_follow: assert property (i_wr && i_addr == OFS_DEVICE_CONTROL
        |=> o_soft_reset == $past(i_wdata[BIT_SOFT_RESET]))
        else $error("soft reset does not follow control write");
    chk_mask_blocks: assert property (i_wr && i_addr == OFS_DEVICE_CONTROL && i_wdata[BIT_INT_MASK_N]
        |-> ##2 !o_irq)
        else $error("interrupt seen while masked");
    chk_index_zero: assert property (i_rd && (i_addr == OFS_STATUS || i_addr == OFS_ALT_STATUS)
        |=> o_rdata[BIT_BUSY] || !o_rdata[BIT_INDEX])
        else $error("index bit read as one");
    chk_alt_keeps_irq: assert property (o_irq && i_rd && !i_wr && i_addr == OFS_ALT_STATUS |=> o_irq)
        else $error("alternate status read cleared interrupt");
    chk_status_clears: assert property (o_irq && i_rd && !i_int_event && i_addr == OFS_STATUS
        |-> ##[1:2] !o_irq)
        else $error("status read left interrupt pending");
    chk_drive_sel_pair: assert property (i_rd && i_addr == OFS_DRIVE_ADDRESS |=> o_rdata[1] != o_rdata[0])
        else $error("drive select bits not complementary");
    cov_cmd: cover property (o_cmd_strobe);
    cov_dma: cover property (o_dmarq);
    cov_irq_alt: cover property (o_irq && i_rd && i_addr == OFS_ALT_STATUS);
    cov_softrst: cover property (o_soft_reset);
endmodule : asr_status_regs_props

bind asr_status_regs asr_status_regs_props #(.CLASS2_LIMIT(CLASS2_LIMIT), .CLASS3_LIMIT(CLASS3_LIMIT)) u_props (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_xfer_done(i_xfer_done), .i_dma_cmd(i_dma_cmd), .i_dma_want(i_dma_want),
    .i_int_event(i_int_event),
    .o_irq(o_irq), .o_dmarq(o_dmarq), .o_soft_reset(o_soft_reset), .o_cmd_strobe(o_cmd_strobe),
    .o_cmd_code(o_cmd_code));

// ---- dv/asr_host_model.sv ----
// Purpose: host controller driving the task-file port
// Assumes: accesses launched at the falling edge
// Notes: released write data shows the inverse of the last byte
`timescale 1ns/1ps
module asr_host_model
    import asr_pkg::*;
(
    // clock
    input wire logic i_clk,
    // task-file port, host side
    input wire logic [7:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [3:0] o_addr,
    output logic [7:0] o_wdata
);
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 4'h0;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge i_clk);
        o_wr = 1'b1;
        o_addr = a;
        o_wdata = v;
        @(negedge i_clk);
        o_wr = 1'b0;
        // a released bus must not look like the last byte
        o_wdata = ~v;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(negedge i_clk);
        o_rd = 1'b1;
        o_addr = a;
        @(negedge i_clk);
        o_rd = 1'b0;
        v = i_rdata;
    endtask : rd
    task automatic cmd(input logic [7:0] dh, input logic [7:0] code);
        logic [7:0] s;
        s = 8'h80;
        // poll the alternate copy so a pending interrupt survives
        for (int i = 0; i < 200 && s[BIT_BUSY]; i++)
            rd(OFS_ALT_STATUS, s);
        if (!s[BIT_BUSY])
        begin
            wr(OFS_DRIVE_HEAD, dh);
            wr(OFS_COMMAND, code);
        end
    endtask : cmd
endmodule : asr_host_model

// ---- dv/asr_status_regs_test.sv ----
// Purpose: self-checking bench for the status and control block
// Assumes: deadlines shortened to 20 cycles
// Notes: core events are pulsed from the bench
`timescale 1ns/1ps
module asr_status_regs_test;
    import asr_pkg::*;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic wr, rd, core_ready = 1'b0, dma_cmd = 1'b0, dma_want = 1'b0;
    logic irq, dmarq, soft_reset, cmd_strobe, write_active;
    logic [1:0] cmd_class = 2'h0;
    logic [3:0] addr;
    logic [5:0] ev = 6'h00;
    logic [7:0] wdata, rdata, cmd_code, d;
    int n_fail = 0;
    int n_checks = 0;
    always #4 i_clk = ~i_clk;
    asr_host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
    asr_status_regs #(.CLASS2_LIMIT(20), .CLASS3_LIMIT(20)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
        .o_rdata(rdata), .i_core_ready(core_ready), .i_cmd_class(cmd_class), .i_buffer_ready(ev[4]),
        .i_xfer_done(ev[3]), .i_cmd_error(ev[2]), .i_write_fault(ev[1]), .i_corrected(ev[0]),
        .i_dma_cmd(dma_cmd), .i_dma_want(dma_want), .i_int_event(ev[5]), .o_irq(irq), .o_dmarq(dmarq),
        .o_soft_reset(soft_reset), .o_cmd_strobe(cmd_strobe), .o_cmd_code(cmd_code), .o_write_active(write_active));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : check
    task automatic st(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp, input string what);
        host.rd(a, d);
        check(what, exp, d & m);
    endtask : st
    task automatic pulse(input logic [5:0] m);
        @(negedge i_clk) ev = m;
        @(negedge i_clk) ev = 6'h00;
        repeat (2) @(negedge i_clk);
    endtask : pulse
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk) i_sys_rst = 1'b0;
        st(OFS_ALT_STATUS, 8'hc0, 8'h80, "status at power up");
        core_ready = 1'b1;
        repeat (4) @(negedge i_clk);
        st(OFS_ALT_STATUS, 8'hff, 8'h50, "idle status");
        host.wr(OFS_DRIVE_HEAD, 8'ha5);
        st(OFS_DRIVE_ADDRESS, 8'h7f, 8'h6a, "drive address drive 0");
        host.wr(OFS_DRIVE_HEAD, 8'hba);
        st(OFS_DRIVE_ADDRESS, 8'h7f, 8'h55, "drive address drive 1");
        $display("test drive address done");
        host.cmd(8'hba, 8'hec);
        check("command code", 8'hec, cmd_code);
        st(OFS_ALT_STATUS, 8'h80, 8'h80, "busy after command");
        host.wr(OFS_DEVICE_CONTROL, 8'h02);
        pulse(6'h20);
        check("masked interrupt", 8'h00, {7'h0, irq});
        host.wr(OFS_DEVICE_CONTROL, 8'hf9);
        @(negedge i_clk);
        check("unmasked interrupt", 8'h01, {7'h0, irq});
        st(OFS_ALT_STATUS, 8'h80, 8'h80, "alternate read");
        check("interrupt after alternate read", 8'h01, {7'h0, irq});
        st(OFS_STATUS, 8'h80, 8'h80, "status read");
        @(negedge i_clk);
        check("interrupt after status read", 8'h00, {7'h0, irq});
        pulse(6'h0f);
        st(OFS_ALT_STATUS, 8'hff, 8'h75, "sticky flags");
        $display("test class 1 done");
        dma_cmd = 1'b1;
        dma_want = 1'b1;
        for (int c = 1; c < 3; c++)
        begin
            cmd_class = c[1:0];
            host.cmd(8'hba, 8'h30 + c[7:0]);
            host.wr(OFS_COMMAND, 8'h00);
            check("command while busy", 8'h30 + c[7:0], cmd_code);
            pulse(6'h10);
            st(OFS_ALT_STATUS, 8'hff, 8'h58, "data request status");
            check("dma request", 8'h03, {6'h0, dmarq, write_active});
            st(OFS_DRIVE_ADDRESS, 8'h7f, 8'h15, "write gate low");
            pulse(6'h08);
            check("dma request dropped", 8'h00, {6'h0, dmarq, write_active});
            st(OFS_ALT_STATUS, 8'hff, 8'h50, "status after transfer");
        end
        $display("test class 2 and 3 done");
        cmd_class = 2'h1;
        host.cmd(8'hba, 8'h38);
        repeat (14) @(negedge i_clk);
        st(OFS_ALT_STATUS, 8'h88, 8'h80, "no early data request");
        repeat (3) @(negedge i_clk);
        st(OFS_ALT_STATUS, 8'h08, 8'h08, "deadline data request");
        pulse(6'h08);
        st(OFS_ALT_STATUS, 8'hff, 8'h50, "status after deadline");
        $display("test deadline done");
        host.wr(OFS_DEVICE_CONTROL, 8'h04);
        check("soft reset held", 8'h01, {7'h0, soft_reset});
        st(OFS_ALT_STATUS, 8'h80, 8'h80, "busy in soft reset");
        st(OFS_DRIVE_ADDRESS, 8'h7f, 8'h7e, "drive address in soft reset");
        host.wr(OFS_DEVICE_CONTROL, 8'h00);
        check("soft reset released", 8'h00, {7'h0, soft_reset});
        repeat (4) @(negedge i_clk);
        st(OFS_ALT_STATUS, 8'hff, 8'h50, "status after soft reset");
        $display("test soft reset done");
        close_out();
    end
    initial
    begin
        #(CLK_PERIOD_NS * 8000);
        n_fail++;
        close_out();
    end
endmodule : asr_status_regs_test
